// ---- slave_map_pkg.sv ----
// constants, types and address decode for the paged slave port mapper
package slave_map_pkg;

  localparam logic [4:0]  CHIP_FIXED  = 5'h0e;
  localparam logic [15:0] REG_BASE    = 16'hf000;
  localparam logic [15:0] REG_TOP     = 16'hfbff;
  localparam logic [15:0] PAGE_REG    = 16'hf899;
  localparam logic [15:0] PROG_BASE   = 16'hc000;
  localparam logic [15:0] PROG_HALF   = 16'h3000;
  localparam logic [15:0] DATA0_BASE  = 16'h0000;
  localparam logic [15:0] DATA0_HALF  = 16'h5000;
  localparam logic [15:0] DATA1_BASE  = 16'h6000;
  localparam logic [15:0] DATA1_HALF  = 16'h5000;
  localparam logic [2:0]  MEM_BYTES   = 3'h4;
  localparam logic [2:0]  REG_BYTES   = 3'h2;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [1:0]  IDX_SUB_LO  = 2'h1;
  localparam logic [1:0]  IDX_DATA    = 2'h2;

  typedef enum logic [2:0] {
    TGT_NONE  = 3'h0,
    TGT_PROG  = 3'h1,
    TGT_DATA0 = 3'h2,
    TGT_DATA1 = 3'h3,
    TGT_REG   = 3'h4
  } target_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_DEVADDR = 3'b001,
    ST_ACK     = 3'b011,
    ST_RX      = 3'b010,
    ST_TX      = 3'b110,
    ST_MACK    = 3'b111
  } state_t;

  typedef struct packed {
    target_t     target;
    logic [15:0] addr;
    logic        valid;
  } map_t;

  typedef struct packed {
    target_t     target;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } core_req_t;

  // a smaller variant only shrinks the *_HALF constants; bases stay put
  function automatic map_t map_addr(input logic [15:0] sub, input logic page);
    map_t m;
    m = '{target: TGT_NONE, addr: 16'h0000, valid: 1'b0};
    if (sub >= REG_BASE && sub <= REG_TOP) begin
      m = '{target: TGT_REG, addr: sub, valid: 1'b1};
    end else if (sub >= PROG_BASE && sub - PROG_BASE < PROG_HALF) begin
      m = '{target: TGT_PROG, addr: sub - PROG_BASE + (page ? PROG_HALF : 16'h0000), valid: 1'b1};
    end else if (sub >= DATA1_BASE && sub - DATA1_BASE < DATA1_HALF) begin
      m = '{target: TGT_DATA1, addr: sub - DATA1_BASE + (page ? DATA1_HALF : 16'h0000),
            valid: 1'b1};
    end else if (sub - DATA0_BASE < DATA0_HALF) begin
      m = '{target: TGT_DATA0, addr: sub - DATA0_BASE + (page ? DATA0_HALF : 16'h0000),
            valid: 1'b1};
    end
    return m;
  endfunction

  function automatic logic [2:0] word_bytes(input target_t t);
    return (t == TGT_REG) ? REG_BYTES : MEM_BYTES;
  endfunction

endpackage

// ---- paged_slave_port_address_mapper.sv ----
// two-wire slave front end and paged address mapper onto the core buses
`timescale 1ns/100ps
`default_nettype none
module paged_slave_port_address_mapper
  import slave_map_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        SCL_PIN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  input  wire logic        ADDRESS_STRAP_LOW,
  input  wire logic        ADDRESS_STRAP_HIGH,
  output core_req_t        CORE_REQ,
  input  wire logic [31:0] PROGRAM_STORE_RDATA,
  input  wire logic [31:0] FIRST_DATA_STORE_RDATA,
  input  wire logic [31:0] SECOND_DATA_STORE_RDATA,
  input  wire logic [15:0] REG_RDATA,
  output logic             UPPER_PAGE_SELECT
);

  logic        scl_meta, scl_sync, scl_prev;
  logic        sda_meta, sda_sync, sda_prev;
  logic        strap_low_meta, strap_low;
  logic        strap_high_meta, strap_high;
  state_t      state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic        rw;
  logic [1:0]  byte_idx;
  logic [15:0] sub;
  logic [2:0]  word_byte;
  logic [31:0] word_buf;
  logic [31:0] rd_word;
  logic [1:0]  rd_stage;
  target_t     rd_tgt;
  logic        rd_page;
  logic        upper_page_select;
  logic        scl_rise, scl_fall, start_cond, stop_cond;
  map_t        cur_map;
  map_t        new_map;
  logic [2:0]  cur_bytes;
  logic [15:0] next_sub;

  // pins sampled by two flops; the slow serial clock leaves ample margin
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= SCL_PIN;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= SDA_IN;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  // straps are wired fixed, so a plain synchroniser is enough
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_low_meta  <= 1'b0;
      strap_low       <= 1'b0;
      strap_high_meta <= 1'b0;
      strap_high      <= 1'b0;
    end else begin
      strap_low_meta  <= ADDRESS_STRAP_LOW;
      strap_low       <= strap_low_meta;
      strap_high_meta <= ADDRESS_STRAP_HIGH;
      strap_high      <= strap_high_meta;
    end
  end

  assign scl_rise   = scl_sync & ~scl_prev;
  assign scl_fall   = ~scl_sync & scl_prev;
  assign start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_cond  = scl_sync & scl_prev & ~sda_prev & sda_sync;

  assign cur_map   = map_addr(sub, upper_page_select);
  assign new_map   = map_addr({sub[15:8], shift}, upper_page_select);
  assign cur_bytes = word_bytes(cur_map.target);
  assign next_sub  = sub + 16'h0001;

  // open drain: only ever pulls low, and only in answer to the master
  assign SDA_OUT           = 1'b0;
  assign UPPER_PAGE_SELECT = upper_page_select;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state             <= ST_IDLE;
      bit_cnt           <= 4'h0;
      shift             <= 8'h00;
      rw                <= 1'b0;
      byte_idx          <= 2'h0;
      sub               <= 16'h0000;
      word_byte         <= 3'h0;
      word_buf          <= 32'h0000_0000;
      rd_word           <= 32'h0000_0000;
      rd_stage          <= 2'h0;
      rd_tgt            <= TGT_NONE;
      rd_page           <= 1'b0;
      upper_page_select <= 1'b0;
      SDA_OE_N          <= 1'b1;
      CORE_REQ          <= '0;
    end else begin
      CORE_REQ.wr <= 1'b0;
      CORE_REQ.rd <= 1'b0;
      rd_stage    <= {rd_stage[0], 1'b0};
      if (rd_stage[1]) begin
        case (rd_tgt)
          TGT_PROG:  rd_word <= PROGRAM_STORE_RDATA;
          TGT_DATA0: rd_word <= FIRST_DATA_STORE_RDATA;
          TGT_DATA1: rd_word <= SECOND_DATA_STORE_RDATA;
          TGT_REG:   rd_word <= rd_page ? {15'h0000, upper_page_select, 16'h0000}
                                        : {REG_RDATA, 16'h0000};
          default:   rd_word <= 32'h0000_0000;
        endcase
      end
      if (start_cond) begin
        state     <= ST_DEVADDR;
        bit_cnt   <= 4'h0;
        byte_idx  <= 2'h0;
        word_byte <= 3'h0;
        SDA_OE_N  <= 1'b1;
      end else if (stop_cond) begin
        state    <= ST_IDLE;
        SDA_OE_N <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            SDA_OE_N <= 1'b1;
          end
          ST_DEVADDR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_sync};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BYTE_BITS) begin
              bit_cnt <= 4'h0;
              if (shift[7:1] == {CHIP_FIXED, strap_high, strap_low}) begin
                rw       <= shift[0];
                SDA_OE_N <= 1'b0;
                state    <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_rise && rw && word_byte == 3'h0) begin
              CORE_REQ.target <= cur_map.target;
              CORE_REQ.addr   <= cur_map.addr;
              CORE_REQ.rd     <= cur_map.valid && sub != PAGE_REG;
              rd_tgt          <= cur_map.target;
              rd_page         <= sub == PAGE_REG;
              rd_stage        <= 2'h1;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rw) begin
                SDA_OE_N <= rd_word[31];
                rd_word  <= {rd_word[30:0], 1'b0};
                bit_cnt  <= 4'h1;
                state    <= ST_TX;
              end else begin
                SDA_OE_N <= 1'b1;
                state    <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_sync};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BYTE_BITS) begin
              bit_cnt  <= 4'h0;
              SDA_OE_N <= 1'b0;
              state    <= ST_ACK;
              if (byte_idx == 2'h0) begin
                sub[15:8] <= shift;
                byte_idx  <= IDX_SUB_LO;
              end else if (byte_idx == IDX_SUB_LO) begin
                if (new_map.valid) begin
                  sub[7:0] <= shift;
                  byte_idx <= IDX_DATA;
                end else begin
                  SDA_OE_N <= 1'b1;
                  state    <= ST_IDLE;
                end
              end else begin
                word_buf <= {word_buf[23:0], shift};
                if (word_byte == cur_bytes - 3'h1) begin
                  word_byte       <= 3'h0;
                  sub             <= next_sub;
                  CORE_REQ.target <= cur_map.target;
                  CORE_REQ.addr   <= cur_map.addr;
                  CORE_REQ.wdata  <= (cur_map.target == TGT_REG)
                                     ? {16'h0000, word_buf[7:0], shift}
                                     : {word_buf[23:0], shift};
                  CORE_REQ.wr     <= cur_map.valid;
                  if (sub == PAGE_REG) begin
                    upper_page_select <= shift[0];
                  end
                end else begin
                  word_byte <= word_byte + 3'h1;
                end
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == BYTE_BITS) begin
                SDA_OE_N <= 1'b1;
                state    <= ST_MACK;
                if (word_byte == cur_bytes - 3'h1) begin
                  word_byte <= 3'h0;
                  sub       <= next_sub;
                end else begin
                  word_byte <= word_byte + 3'h1;
                end
              end else begin
                SDA_OE_N <= rd_word[31];
                rd_word  <= {rd_word[30:0], 1'b0};
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_sync) begin
                state <= ST_IDLE;
              end else if (word_byte == 3'h0) begin
                CORE_REQ.target <= cur_map.target;
                CORE_REQ.addr   <= cur_map.addr;
                CORE_REQ.rd     <= cur_map.valid && sub != PAGE_REG;
                rd_tgt          <= cur_map.target;
                rd_page         <= sub == PAGE_REG;
                rd_stage        <= 2'h1;
              end
            end else if (scl_fall) begin
              SDA_OE_N <= rd_word[31];
              rd_word  <= {rd_word[30:0], 1'b0};
              bit_cnt  <= 4'h1;
              state    <= ST_TX;
            end
          end
          default: begin
            state    <= ST_IDLE;
            SDA_OE_N <= 1'b1;
          end
        endcase
      end
    end
  end

  a_map_steer: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CORE_REQ.wr && CORE_REQ.target inside {TGT_PROG, TGT_DATA0, TGT_DATA1}
    |-> $past(upper_page_select) == (CORE_REQ.addr >=
        ((CORE_REQ.target == TGT_PROG)  ? PROG_HALF  :
         (CORE_REQ.target == TGT_DATA0) ? DATA0_HALF : DATA1_HALF)))
    else $error("write address not steered by page select");

  a_reg_unpaged: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CORE_REQ.wr && CORE_REQ.target == TGT_REG |-> CORE_REQ.addr == $past(sub))
    else $error("register window address altered");

  a_data1_lower: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CORE_REQ.wr && CORE_REQ.target == TGT_DATA1 && !$past(upper_page_select)
    |-> CORE_REQ.addr == $past(sub) - DATA1_BASE)
    else $error("second data lower page address wrong");

  a_data1_upper: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CORE_REQ.wr && CORE_REQ.target == TGT_DATA1 && $past(upper_page_select)
    |-> CORE_REQ.addr == $past(sub) - DATA1_BASE + DATA1_HALF)
    else $error("second data upper page address wrong");

  a_prog_map: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CORE_REQ.wr && CORE_REQ.target == TGT_PROG |-> CORE_REQ.addr ==
    $past(sub) - PROG_BASE + ($past(upper_page_select) ? PROG_HALF : 16'h0000))
    else $error("program address wrong");

  a_data0_map: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CORE_REQ.wr && CORE_REQ.target == TGT_DATA0 |-> CORE_REQ.addr ==
    $past(sub) + ($past(upper_page_select) ? DATA0_HALF : 16'h0000))
    else $error("first data address wrong");

  a_idle_quiet: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    state == ST_IDLE && $past(state) == ST_IDLE |-> SDA_OE_N)
    else $error("line driven while idle");

  a_chip_match: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    state == ST_ACK && $past(state) == ST_DEVADDR
    |-> $past(shift[7:1]) == {CHIP_FIXED, strap_high, strap_low} && !SDA_OE_N)
    else $error("acknowledged a foreign chip address");

  a_dir_bit: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    state == ST_ACK && $past(state) == ST_DEVADDR |-> rw == $past(shift[0]))
    else $error("direction bit misread");

  a_bad_sub: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $past(state) == ST_RX && state == ST_IDLE |-> SDA_OE_N)
    else $error("acknowledge on rejected subaddress");

  a_sub_step: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CORE_REQ.wr |-> sub == $past(sub) + 16'h0001)
    else $error("subaddress did not advance by one");

  a_unmapped: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CORE_REQ.wr || CORE_REQ.rd |-> CORE_REQ.target != TGT_NONE)
    else $error("access issued to unmapped address");

endmodule
`default_nettype wire

// ---- two_wire_master_model.sv ----
// behavioural two-wire bus master that faces the slave port
`timescale 1ns/100ps
`default_nettype none
module two_wire_master_model #(
  parameter int QTR = 40
) (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  // clock idles high between frames; data released to the pull-up
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // every frame is opened here, never by the device
  task automatic start_cond();
    sda_drv = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b0;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b1;
    #QTR;
  endtask

  task automatic put_bit(input logic b);
    sda_drv = b;
    #QTR scl = 1'b1;
    #(2 * QTR) scl = 1'b0;
    #QTR;
  endtask

  // data released first, so a bit not driven by the device reads high
  task automatic get_bit(output logic b);
    sda_drv = 1'b1;
    #QTR scl = 1'b1;
    #QTR b = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask

  task automatic rd_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
endmodule
`default_nettype wire

// ---- paged_slave_port_address_mapper_tb.sv ----
// self-checking bench for the paged slave port mapper
`timescale 1ns/100ps
`default_nettype none
module paged_slave_port_address_mapper_tb;
  import slave_map_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  straps = 2'h0;
  logic [31:0] prog_rd = 32'h0;
  logic [31:0] dat0_rd = 32'h0;
  logic [31:0] dat1_rd = 32'h0;
  logic [15:0] reg_rd = 16'h0;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe_n;
  logic        page_pin;
  wire logic   sda = sda_drv & (sda_oe_n | sda_out);
  core_req_t   req;
  core_req_t   exp_q[$];
  logic [31:0] mem[int];
  logic        page = 1'b0;
  integer      seed = 32'ha6b2bd82;
  int          mismatches = 0;
  int          compares = 0;
  int          rk;
  logic [15:0] subs[6] = '{16'h6000, 16'hafff, 16'hc000, 16'hefff, 16'h4fff, 16'hf000};
  int          lens[6] = '{4, 8, 4, 6, 8, 2};

  always #2.5 ref_clk = ~ref_clk;

  paged_slave_port_address_mapper uut (.REF_CLK(ref_clk), .RST_N(rst_n), .SCL_PIN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDRESS_STRAP_LOW(straps[0]),
    .ADDRESS_STRAP_HIGH(straps[1]), .CORE_REQ(req), .PROGRAM_STORE_RDATA(prog_rd),
    .FIRST_DATA_STORE_RDATA(dat0_rd), .SECOND_DATA_STORE_RDATA(dat1_rd),
    .REG_RDATA(reg_rd), .UPPER_PAGE_SELECT(page_pin));

  two_wire_master_model m (.scl(scl), .sda_drv(sda_drv), .sda(sda));

  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_req(input string nm, input core_req_t e, input core_req_t g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // core-side key: target in the upper half, native address below
  function automatic int map_key(input logic [15:0] s);
    int o;
    o = page ? 1 : 0;
    if (s >= 16'hf000 && s <= 16'hfbff) return 4 * 65536 + s;
    if (s >= 16'hc000 && s <= 16'hefff) return 65536 + s - 16'hc000 + o * 16'h3000;
    if (s >= 16'h6000 && s <= 16'hafff) return 3 * 65536 + s - 16'h6000 + o * 16'h5000;
    if (s <= 16'h4fff) return 2 * 65536 + s + o * 16'h5000;
    return -1;
  endfunction

  function automatic int word_len(input logic [15:0] s);
    return ((map_key(s) >>> 16) == 4) ? 2 : 4;
  endfunction

  function automatic logic [31:0] word_val(input logic [15:0] s);
    int k;
    k = map_key(s);
    if (k < 0 || !mem.exists(k)) return 32'h0;
    if (s == 16'hf899) return {31'h0, page};
    return ((k >>> 16) == 4) ? {16'h0, mem[k][15:0]} : mem[k];
  endfunction

  // core side: wrong buses carry the inverse so a bad select shows
  always @(negedge ref_clk) begin
    if (req.rd === 1'b1) begin
      rk = int'(req.target) * 65536 + int'(req.addr);
      if (!mem.exists(rk)) mem[rk] = $random(seed);
      prog_rd <= (req.target == TGT_PROG) ? mem[rk] : ~mem[rk];
      dat0_rd <= (req.target == TGT_DATA0) ? mem[rk] : ~mem[rk];
      dat1_rd <= (req.target == TGT_DATA1) ? mem[rk] : ~mem[rk];
      reg_rd <= (req.target == TGT_REG) ? mem[rk][15:0] : ~mem[rk][15:0];
    end
  end

  // looked at mid-cycle, where the one-cycle pulse has settled
  always @(negedge ref_clk) begin
    if (req.wr === 1'b1 && req.target !== TGT_NONE) begin
      if (exp_q.size() == 0) chk_bit("spare write", 1'b0, 1'b1);
      else chk_req("write request", exp_q.pop_front(), req);
    end
  end

  task automatic do_reset(input logic [1:0] st);
    rst_n = 1'b0;
    straps = st;
    page = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    chk_req("reset request", '0, req);
    chk_bit("reset page", 1'b0, page_pin);
    chk_bit("reset data pin", 1'b1, sda_oe_n);
    chk_bit("pull level", 1'b0, sda_out);
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic tail();
    m.stop_cond();
    repeat (8) @(negedge ref_clk);
    chk_bit("bus released", 1'b1, sda_oe_n);
    chk_bit("writes drained", 1'b1, exp_q.size() == 0);
    chk_bit("page bit", page, page_pin);
  endtask

  task automatic probe(input logic [7:0] b, input logic ok);
    logic a;
    @(negedge ref_clk);
    m.start_cond();
    m.wr_byte(b, a);
    chk_bit("chip match", ok, a);
    tail();
  endtask

  task automatic head(input logic [15:0] s, input logic ok);
    logic a;
    @(negedge ref_clk);
    m.start_cond();
    m.wr_byte({5'b01110, straps, 1'b0}, a);
    chk_bit("chip ack", 1'b1, a);
    m.wr_byte(s[15:8], a);
    chk_bit("sub high ack", 1'b1, a);
    m.wr_byte(s[7:0], a);
    chk_bit("sub low ack", ok, a);
  endtask

  // expectation is queued before the last byte: the pulse lands inside its ack bit
  task automatic xfer_w(input logic [15:0] s, input int n, input logic ok, input int val);
    logic        a;
    logic [7:0]  d;
    logic [31:0] acc;
    int          c;
    int          k;
    acc = 32'h0;
    c = 0;
    head(s, ok);
    for (int i = 0; i < n; i++) begin
      d = (val < 0) ? 8'($random(seed)) : 8'(val);
      acc = {acc[23:0], d};
      c++;
      if (c == word_len(s)) begin
        k = map_key(s);
        if (k >= 0) begin
          exp_q.push_back('{target: target_t'(k >>> 16), addr: 16'(k), wdata: acc,
                            wr: 1'b1, rd: 1'b0});
          mem[k] = acc;
        end
        if (s == 16'hf899) page = acc[0];
        s = s + 16'h1;
        c = 0;
        acc = 32'h0;
      end
      m.wr_byte(d, a);
      chk_bit("data ack", 1'b1, a);
    end
    tail();
  endtask

  task automatic xfer_r(input logic [15:0] s, input int n);
    logic        a;
    logic [7:0]  d;
    logic [31:0] w;
    int          c;
    c = 0;
    head(s, 1'b1);
    m.start_cond();
    m.wr_byte({5'b01110, straps, 1'b1}, a);
    chk_bit("read chip ack", 1'b1, a);
    for (int i = 0; i < n; i++) begin
      if (c == 0) w = word_val(s);
      m.rd_byte(d, i == n - 1);
      chk_byte("read byte", w[8 * (word_len(s) - 1 - c) +: 8], d);
      c++;
      if (c == word_len(s)) begin
        s = s + 16'h1;
        c = 0;
      end
    end
    tail();
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      probe({5'b01110, 2'(s), 1'b0}, 1'b1);
      probe({5'b01110, ~2'(s), 1'b0}, 1'b0);
    end
    $display("test straps done");
    for (int p = 0; p < 2; p++) begin
      xfer_w(16'hf899, 2, 1'b1, p);
      for (int i = 0; i < 6; i++) xfer_w(subs[i], lens[i], 1'b1, -1);
    end
    $display("test paged writes done");
    for (int i = 0; i < 6; i++) xfer_r(subs[i], lens[i]);
    xfer_r(16'hf899, 2);
    $display("test paged reads done");
    xfer_w(16'h6000, 3, 1'b1, -1);
    xfer_w(16'hb000, 0, 1'b0, -1);
    xfer_w(16'hfc00, 0, 1'b0, -1);
    xfer_w(16'h0000, 4, 1'b1, -1);
    $display("test refusals done");
    wrap_up();
  end

  // about 200 bytes at 1.44 us each, half again as margin, under 100k clocks
  initial begin
    #450000;
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
